// *** clc_bus_master.sv ***
// clc_bus_master: system bus side model writing byte queue zero
// assumes the queue samples its strobes on the rising edge of clk_sys
`timescale 1ns/10ps
module clc_bus_master (
   input  wire logic          clk_sys,
   output clc_pkg::clc_qbus_t bus_q
);
   initial bus_q = '0;
   ////////////////////////////////////////////////////
   // one byte per call; held until the sampling edge, then data inverted
   // so a stale value never passes for a fresh one
   task automatic push(input logic [7:0] b);
      @(posedge clk_sys) #1;
      bus_q.wdata = b;
      bus_q.wr = 1'b1;
      @(posedge clk_sys) #1;
      bus_q.wr = 1'b0;
      bus_q.wdata = ~b;
   endtask
endmodule

// *** clc_byte_queue.sv ***
// clc_byte_queue: four-entry byte queue, one side per direction
// assumes write and read strobes are single-cycle and synchronous to clk_sys
`timescale 1ns/10ps
module clc_byte_queue (
   input  wire logic                           clk_sys,
   input  wire logic                           rst,
   input  wire logic                           en,
   input  wire logic                           wr,
   input  wire logic [clc_pkg::DW-1:0]         wdata,
   input  wire logic                           rd,
   output logic      [clc_pkg::DW-1:0]         rdata,
   output logic                                empty,
   output logic                                full
);
   typedef struct packed {
      logic [clc_pkg::Q_DEPTH-1:0][clc_pkg::DW-1:0] mem;
      logic [clc_pkg::Q_PTR_W-1:0]                  wp;
      logic [clc_pkg::Q_PTR_W-1:0]                  rp;
      logic [clc_pkg::Q_CNT_W-1:0]                  cnt;
   } clc_q_t;

   clc_q_t q_r;
   clc_q_t q_nxt;
   logic   do_wr;
   logic   do_rd;

   assign empty = (q_r.cnt == '0);
   assign full  = (q_r.cnt == clc_pkg::Q_CNT_W'(clc_pkg::Q_DEPTH));
   assign rdata = q_r.mem[q_r.rp];
   assign do_wr = en && wr && !full;
   assign do_rd = en && rd && !empty;

   always_comb begin
      q_nxt = q_r;
      if (do_wr) begin
         q_nxt.mem[q_r.wp] = wdata;
         q_nxt.wp          = q_r.wp + 1'b1;
      end
      if (do_rd) begin
         q_nxt.rp = q_r.rp + 1'b1;
      end
      if (do_wr && !do_rd) begin
         q_nxt.cnt = q_r.cnt + 1'b1;
      end else if (do_rd && !do_wr) begin
         q_nxt.cnt = q_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   full_blocks_a: assert property (@(posedge clk_sys) disable iff (rst)
      full && wr && !rd |=> $stable(q_r.cnt)) else $error("queue overfilled");
   count_track_a: assert property (@(posedge clk_sys) disable iff (rst)
      do_wr && !do_rd |=> q_r.cnt == $past(q_r.cnt) + 1'b1) else $error("count lost a write");
endmodule

// *** clc_datapath.sv ***
// clc_datapath: byte-wide configurable datapath with status and control pair
// assumes routing and system bus strobes are synchronous to clk_sys
`timescale 1ns/10ps
module clc_datapath (
   input  wire logic                               clk_sys,
   input  wire logic                               rst,
   input  wire logic                               dp_clk_en,
   input  wire logic                               sc_clk_en,
   input  wire logic [clc_pkg::ROUTE_IN_W-1:0]     route_in,
   output logic      [clc_pkg::ROUTE_OUT_W-1:0]    route_out,
   input  wire logic                               cfg_we,
   input  wire logic [2:0]                         cfg_waddr,
   input  wire logic [clc_pkg::CFG_W-1:0]          cfg_wdata,
   input  wire logic [clc_pkg::DW-1:0]             operand_reg_zero_init,
   input  wire logic [clc_pkg::DW-1:0]             operand_reg_one_init,
   input  wire logic                               operand_we,
   input  wire logic [2:0]                         msb_pos,
   input  wire logic [clc_pkg::DW-1:0]             or_mask,
   input  wire logic [clc_pkg::DW-1:0]             poly,
   input  wire logic [clc_pkg::DW-1:0]             cmp_mask0,
   input  wire logic [clc_pkg::DW-1:0]             cmp_mask1,
   input  wire logic [1:0]                         cmp_sel,
   input  wire logic [1:0]                         chain_mode,
   input  wire logic [3:0]                         out_sel [clc_pkg::ROUTE_OUT_W],
   input  wire logic                               queue_zero_is_out,
   input  wire logic                               queue_one_is_out,
   input  wire clc_pkg::clc_qbus_t                 bus_q0,
   input  wire clc_pkg::clc_qbus_t                 bus_q1,
   output logic      [clc_pkg::DW-1:0]             bus_q0_rdata,
   output logic      [clc_pkg::DW-1:0]             bus_q1_rdata,
   input  wire clc_pkg::clc_chain_t                chain_prev_in,
   input  wire clc_pkg::clc_chain_t                chain_next_in,
   output clc_pkg::clc_chain_t                     chain_next_out,
   output clc_pkg::clc_chain_t                     chain_prev_out,
   input  wire logic                               ctrl_we,
   input  wire logic [clc_pkg::CTRL_W-1:0]         ctrl_wdata,
   output logic      [clc_pkg::CTRL_W-1:0]         ctrl_route,
   input  wire logic [clc_pkg::STAT_W-1:0]         stat_route,
   input  wire logic [clc_pkg::STAT_W-1:0]         stat_sticky_en,
   input  wire logic                               stat_rd,
   output logic      [clc_pkg::STAT_W-1:0]         stat_rdata,
   output logic      [clc_pkg::DW-1:0]             accumulator_zero,
   output logic      [clc_pkg::DW-1:0]             accumulator_one
);
   localparam int unsigned DW = clc_pkg::DW;

   typedef struct packed {
      logic [DW-1:0]                  acc0;
      logic [DW-1:0]                  acc1;
      logic [DW-1:0]                  opr0;
      logic [DW-1:0]                  opr1;
      logic                           cy_reg;
      logic                           sh_reg;
      clc_pkg::clc_state_t            bank;
      logic [clc_pkg::ROUTE_OUT_W-1:0] rout;
      clc_pkg::clc_chain_t            nx_out;
      clc_pkg::clc_chain_t            pv_out;
      logic [clc_pkg::CTRL_W-1:0]     ctrl;
      logic [clc_pkg::STAT_W-1:0]     stat;
      logic [DW-1:0]                  q0_rd;
      logic [DW-1:0]                  q1_rd;
   } clc_dp_t;

   clc_dp_t s_r;
   clc_dp_t s_nxt;

   logic [clc_pkg::CFG_W-1:0] cfg_mem [clc_pkg::CFG_WORDS];
   logic [clc_pkg::CFG_W-1:0] cfg;

   ////////////////////////////////////////////////////////////////////////////
   // configuration store, addressed from routing
   always_ff @(posedge clk_sys) begin
      if (cfg_we) begin
         cfg_mem[cfg_waddr] <= cfg_wdata;
      end
   end
   assign cfg = cfg_mem[route_in[2:0]];

   clc_pkg::clc_func_t  fn;
   clc_pkg::clc_shift_t sh;
   clc_pkg::clc_cin_t   cin_sel;
   logic [1:0] src_a;
   logic [1:0] src_b;
   logic       sin_sel;
   logic [1:0] dst;
   logic       crc_mode;
   logic       bank_sel;
   assign fn       = clc_pkg::clc_func_t'(cfg[clc_pkg::CF_FUNC_LSB +: 3]);
   assign src_a    = cfg[clc_pkg::CF_SRCA_LSB +: 2];
   assign src_b    = cfg[clc_pkg::CF_SRCB_LSB +: 2];
   assign sh       = clc_pkg::clc_shift_t'(cfg[clc_pkg::CF_SHIFT_LSB +: 2]);
   assign cin_sel  = clc_pkg::clc_cin_t'(cfg[clc_pkg::CF_CIN_LSB +: 2]);
   assign sin_sel  = cfg[clc_pkg::CF_SIN_LSB];
   assign dst      = cfg[clc_pkg::CF_DST_LSB +: 2];
   assign crc_mode = cfg[clc_pkg::CF_CRC_BIT];
   assign bank_sel = cfg[clc_pkg::CF_BANK_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // byte queues
   logic [DW-1:0] q0_data;
   logic [DW-1:0] q1_data;
   logic q0_empty;
   logic q0_full;
   logic q1_empty;
   logic q1_full;
   logic [DW-1:0] alu_out;
   logic [DW-1:0] res;

   // direction picks who writes and who reads
   clc_byte_queue u_queue_zero (
      .clk_sys (clk_sys),
      .rst     (rst),
      .en      (dp_clk_en),
      .wr      (queue_zero_is_out ? route_in[3] : bus_q0.wr),
      .wdata   (queue_zero_is_out ? s_r.acc0 : bus_q0.wdata),
      .rd      (queue_zero_is_out ? bus_q0.rd : route_in[4]),
      .rdata   (q0_data),
      .empty   (q0_empty),
      .full    (q0_full)
   );
   clc_byte_queue u_queue_one (
      .clk_sys (clk_sys),
      .rst     (rst),
      .en      (dp_clk_en),
      .wr      (queue_one_is_out ? route_in[3] : bus_q1.wr),
      .wdata   (queue_one_is_out ? res : bus_q1.wdata),
      .rd      (queue_one_is_out ? bus_q1.rd : route_in[4]),
      .rdata   (q1_data),
      .empty   (q1_empty),
      .full    (q1_full)
   );

   ////////////////////////////////////////////////////////////////////////////
   // alu, shift and mask
   logic [DW-1:0] opa;
   logic [DW-1:0] opb;
   logic [DW:0]   sum;
   logic          cin;
   logic          cout;
   logic          sout;
   logic          sin;
   logic          ovf;
   logic [DW-1:0] width_mask;
   logic          fb;

   always_comb begin
      case (src_a)
         2'd0:    opa = s_r.acc0;
         2'd1:    opa = s_r.acc1;
         2'd2:    opa = s_r.opr0;
         default: opa = s_r.opr1;
      endcase
      case (src_b)
         2'd0:    opb = s_r.opr0;
         2'd1:    opb = s_r.opr1;
         2'd2:    opb = s_r.acc1;
         default: opb = q0_data;
      endcase
      case (cin_sel)
         clc_pkg::CI_ZERO:  cin = 1'b0;
         clc_pkg::CI_ONE:   cin = 1'b1;
         clc_pkg::CI_CHAIN: cin = chain_prev_in.cy;
         default:           cin = s_r.cy_reg;
      endcase
   end

   always_comb begin
      width_mask = BYTE_MASK(msb_pos);
      sum = '0;
      case (fn)
         clc_pkg::FN_INC: sum = {1'b0, opa} + 9'd1;
         clc_pkg::FN_DEC: sum = {1'b0, opa} - 9'd1;
         clc_pkg::FN_ADD: sum = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
         clc_pkg::FN_SUB: sum = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
         clc_pkg::FN_AND: sum = {1'b0, opa & opb};
         clc_pkg::FN_OR:  sum = {1'b0, opa | opb};
         clc_pkg::FN_XOR: sum = {1'b0, opa ^ opb};
         default:         sum = {1'b0, opa};
      endcase
      alu_out = sum[DW-1:0] & width_mask;
      // carry taken at the programmed msb so narrow counters chain correctly
      cout = (msb_pos == 3'd7) ? sum[DW] : sum[msb_pos + 1'b1];
      ovf  = (opa[msb_pos] == opb[msb_pos]) && (alu_out[msb_pos] != opa[msb_pos])
             && (fn == clc_pkg::FN_ADD);
   end

   assign sin = sin_sel ? chain_prev_in.sh : route_in[5];

   always_comb begin
      res  = alu_out;
      sout = 1'b0;
      fb   = alu_out[msb_pos] ^ sin;
      case (sh)
         clc_pkg::SH_LEFT: begin
            sout = alu_out[msb_pos];
            res  = {alu_out[DW-2:0], sin} & width_mask;
            if (crc_mode && fb) begin
               res = ({alu_out[DW-2:0], 1'b0} ^ poly) & width_mask;
            end else if (crc_mode) begin
               res = {alu_out[DW-2:0], 1'b0} & width_mask;
            end
         end
         clc_pkg::SH_RIGHT: begin
            sout = alu_out[0];
            res  = alu_out >> 1;
            res[msb_pos] = s_r.sh_reg ? chain_next_in.sh : sin;
         end
         clc_pkg::SH_SWAP: res = {alu_out[3:0], alu_out[7:4]};
         default:          res = alu_out;
      endcase
      res = res | or_mask;
   end

   function automatic logic [DW-1:0] BYTE_MASK(input logic [2:0] m);
      logic [DW-1:0] v;
      v = '0;
      for (int i = 0; i < DW; i++) begin
         v[i] = (i <= int'(m));
      end
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // conditions
   logic [DW-1:0] ca0;
   logic [DW-1:0] cb0;
   logic [DW-1:0] ca1;
   logic [DW-1:0] cb1;
   logic [clc_pkg::COND_W-1:0] cond;
   logic chain_c;

   always_comb begin
      case (cmp_sel)
         2'd0:    begin ca0 = s_r.acc0; cb0 = s_r.opr0; ca1 = s_r.acc1; cb1 = s_r.opr1; end
         2'd1:    begin ca0 = s_r.acc0; cb0 = s_r.acc1; ca1 = s_r.acc1; cb1 = s_r.opr1; end
         2'd2:    begin ca0 = s_r.acc0; cb0 = s_r.opr0; ca1 = s_r.acc0; cb1 = s_r.opr1; end
         default: begin ca0 = s_r.acc1; cb0 = s_r.opr0; ca1 = s_r.acc0; cb1 = s_r.acc1; end
      endcase
      // chained term widens the equal compare across cells
      chain_c = (chain_mode == 2'd1) ? chain_prev_in.cond :
                (chain_mode == 2'd2) ? chain_next_in.cond : 1'b1;
      cond = '0;
      cond[clc_pkg::C_CMP0]   = ((ca0 & cmp_mask0) == (cb0 & cmp_mask0)) && chain_c;
      cond[clc_pkg::C_CMP1]   = ((ca1 & cmp_mask1) == (cb1 & cmp_mask1));
      cond[clc_pkg::C_CMPLT0] = (ca0 & cmp_mask0) < (cb0 & cmp_mask0);
      cond[clc_pkg::C_CMPLT1] = (ca1 & cmp_mask1) < (cb1 & cmp_mask1);
      cond[clc_pkg::C_ZERO0]  = (s_r.acc0 == clc_pkg::BYTE_ZERO) && chain_c;
      cond[clc_pkg::C_ZERO1]  = (s_r.acc1 == clc_pkg::BYTE_ZERO);
      cond[clc_pkg::C_ONES0]  = (s_r.acc0 == clc_pkg::BYTE_ONES);
      cond[clc_pkg::C_ONES1]  = (s_r.acc1 == clc_pkg::BYTE_ONES);
      cond[clc_pkg::C_OVF]    = ovf;
      cond[clc_pkg::C_COUT]   = s_r.cy_reg;
      cond[clc_pkg::C_SOUT]   = s_r.sh_reg;
      cond[clc_pkg::C_Q0_EMP] = q0_empty;
      cond[clc_pkg::C_Q0_FUL] = q0_full;
      cond[clc_pkg::C_Q1_EMP] = q1_empty;
      cond[clc_pkg::C_Q1_FUL] = q1_full;
      cond[clc_pkg::C_CHAIN]  = chain_c;
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_nxt = s_r;
      if (operand_we) begin
         s_nxt.opr0 = operand_reg_zero_init;
         s_nxt.opr1 = operand_reg_one_init;
      end
      if (dp_clk_en) begin
         s_nxt.cy_reg = cout;
         s_nxt.sh_reg = sout;
         s_nxt.bank   = bank_sel ? clc_pkg::ST_BANK1 : clc_pkg::ST_BANK0;
         case (dst)
            2'd1:    s_nxt.acc0 = res;
            2'd2:    s_nxt.acc1 = res;
            2'd3:    s_nxt.acc0 = q0_data;
            default: ;
         endcase
         for (int i = 0; i < clc_pkg::ROUTE_OUT_W; i++) begin
            s_nxt.rout[i] = (out_sel[i] == 4'hF) ? sout : cond[out_sel[i]];
         end
         s_nxt.nx_out = '{cy: cout, sh: sout, cond: cond[clc_pkg::C_CMP0]};
         s_nxt.pv_out = '{cy: 1'b0, sh: alu_out[0], cond: cond[clc_pkg::C_ZERO0]};
      end
      s_nxt.q0_rd = q0_data;
      s_nxt.q1_rd = q1_data;
      if (sc_clk_en) begin
         if (ctrl_we) begin
            s_nxt.ctrl = ctrl_wdata;
         end
         for (int i = 0; i < clc_pkg::STAT_W; i++) begin
            if (stat_sticky_en[i]) begin
               // set wins over the read-clear so no event is lost
               s_nxt.stat[i] = stat_route[i] | (s_r.stat[i] & !stat_rd);
            end else begin
               s_nxt.stat[i] = stat_route[i];
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_r      <= '0;
         s_r.bank <= clc_pkg::ST_BANK0;
         s_r.ctrl <= clc_pkg::CTRL_RST;
         s_r.stat <= clc_pkg::STAT_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign route_out        = s_r.rout;
   assign chain_next_out   = s_r.nx_out;
   assign chain_prev_out   = s_r.pv_out;
   assign ctrl_route       = s_r.ctrl;
   assign stat_rdata       = s_r.stat;
   assign accumulator_zero = s_r.acc0;
   assign accumulator_one  = s_r.acc1;
   assign bus_q0_rdata     = s_r.q0_rd;
   assign bus_q1_rdata     = s_r.q1_rd;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence inc_req_s;
      dp_clk_en && fn == clc_pkg::FN_INC && dst == 2'd1 && sh == clc_pkg::SH_NONE
      && msb_pos == 3'd7 && or_mask == 8'h00;
   endsequence
   inc_step_a: assert property (@(posedge clk_sys) disable iff (rst)
      inc_req_s |=> s_r.acc0 == $past(opa) + 8'h01) else $error("increment wrong");
   swap_op_a: assert property (@(posedge clk_sys) disable iff (rst)
      dp_clk_en && sh == clc_pkg::SH_SWAP && dst == 2'd2 && or_mask == 8'h00
      |=> s_r.acc1 == {$past(alu_out[3:0]), $past(alu_out[7:4])}) else $error("swap wrong");
   mask_apply_a: assert property (@(posedge clk_sys) disable iff (rst)
      dp_clk_en && dst == 2'd1 |=> (s_r.acc0 & $past(or_mask)) == $past(or_mask))
      else $error("or mask lost");
   zero_route_a: assert property (@(posedge clk_sys) disable iff (rst)
      dp_clk_en && out_sel[0] == 4'd2 |=> route_out[0] == $past(cond[clc_pkg::C_ZERO0]))
      else $error("zero route wrong");
   carry_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      dp_clk_en |=> s_r.cy_reg == $past(cout)) else $error("carry not kept");
   ctrl_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
      !(sc_clk_en && ctrl_we) |=> $stable(ctrl_route)) else $error("ctrl drifted");
   ctrl_write_a: assert property (@(posedge clk_sys) disable iff (rst)
      sc_clk_en && ctrl_we |=> ctrl_route == $past(ctrl_wdata)) else $error("ctrl not written");
   sticky_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      sc_clk_en && stat_sticky_en[0] && stat_route[0] ##1 (sc_clk_en && !stat_rd)[*2]
      |-> stat_rdata[0]) else $error("sticky bit dropped");
   width_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
      dp_clk_en && dst == 2'd1 && or_mask == 8'h00 && sh != clc_pkg::SH_SWAP
      |=> (s_r.acc0 & ~BYTE_MASK($past(msb_pos))) == 8'h00) else $error("msb mask wrong");
endmodule

// *** clc_datapath_tb_top.sv ***
// clc_datapath_tb_top: self-checking bench for the logic cell datapath
// assumes clc_bus_master feeds queue zero, which starts as an input buffer
`timescale 1ns/10ps
module clc_datapath_tb_top;
   logic               clk_sys, rst, dp_en, sc_en, cfg_we, operand_we, ctrl_we, stat_rd;
   logic [5:0]         route_in, route_out;
   logic [15:0]        cfg_wdata;
   logic [7:0]         or_mask, ctrl_wdata, ctrl_route, stat_route;
   logic [7:0]         stat_sticky_en, stat_rdata, acc0, acc1;
   logic [3:0]         out_sel [6];
   clc_pkg::clc_qbus_t bus_q0;
   logic [2:0]         cfg_waddr, msb_pos;
   logic [7:0]         opr_init0, opr_init1, cmp_mask0, q0_rdata;
   logic [1:0]         cmp_sel, chain_mode;
   logic               q0_is_out;
   clc_pkg::clc_chain_t chain_prev, chain_nx;
   int                 fail_count = 0;
   int                 n_compared = 0;
   // config word, or mask, expected acc0; operand regs hold 35 and 0f
   logic [31:0]        rows [12] = '{32'h1030_0035, 32'h1031_0036, 32'h1032_0034,
      32'h1033_0044, 32'h1034_0026, 32'h1035_0005, 32'h1036_003F, 32'h1037_003A,
      32'h10B0_006A, 32'h1130_001A, 32'h11B0_0053, 32'h1030_80B5};

   clc_bus_master i_bus (.clk_sys(clk_sys), .bus_q(bus_q0));
   clc_datapath i_dut (
      .clk_sys(clk_sys), .rst(rst), .dp_clk_en(dp_en), .sc_clk_en(sc_en),
      .route_in(route_in), .route_out(route_out), .cfg_we(cfg_we), .cfg_waddr(cfg_waddr),
      .cfg_wdata(cfg_wdata), .operand_reg_zero_init(opr_init0), .operand_reg_one_init(opr_init1),
      .operand_we(operand_we), .msb_pos(msb_pos), .or_mask(or_mask), .poly(8'h00),
      .cmp_mask0(cmp_mask0), .cmp_mask1(8'h00), .cmp_sel(cmp_sel), .chain_mode(chain_mode),
      .out_sel(out_sel), .queue_zero_is_out(q0_is_out), .queue_one_is_out(1'b0),
      .bus_q0(bus_q0), .bus_q1('0), .bus_q0_rdata(q0_rdata), .bus_q1_rdata(),
      .chain_prev_in(chain_prev), .chain_next_in('0), .chain_next_out(chain_nx),
      .chain_prev_out(),
      .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata), .ctrl_route(ctrl_route),
      .stat_route(stat_route), .stat_sticky_en(stat_sticky_en), .stat_rd(stat_rd),
      .stat_rdata(stat_rdata), .accumulator_zero(acc0), .accumulator_one(acc1));
   ////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // hang guard, far beyond the longest sequence
   initial begin
      repeat (5000) @(posedge clk_sys);
      fail_count++;
      close_out;
   end
   initial begin
      {rst, sc_en} = 2'b11;
      {dp_en, cfg_we, operand_we, ctrl_we, stat_rd} = 5'h00;
      {route_in, cfg_wdata, or_mask, ctrl_wdata, stat_route, stat_sticky_en} = '0;
      {cfg_waddr, msb_pos, cmp_sel, chain_mode, q0_is_out} = {3'h0, 3'h7, 2'h0, 2'h0, 1'b0};
      {opr_init0, opr_init1, cmp_mask0, chain_prev} = {8'h35, 8'h0F, 8'h00, 3'h0};
      foreach (out_sel[i]) out_sel[i] = 4'h0;
      out_sel[0] = 4'hA;
      out_sel[1] = 4'h9;
      tick(4);
      rst = 1'b0;
      tick(1);
      check({acc0, acc1}, 16'h0000);
      check({ctrl_route, stat_rdata}, 16'h0000);
      $display("reset test done");
      dp_en = 1'b1;
      operand_we = 1'b1;
      for (int i = 0; i < 12; i++) begin
         cfg_wdata = rows[i][31:16];
         or_mask = rows[i][15:8];
         cfg_we = 1'b1;
         tick(1);
         {cfg_we, operand_we} = 2'b00;
         tick(2);
         check({8'h00, acc0}, {8'h00, rows[i][7:0]});
      end
      // gated datapath must ignore a new mask
      dp_en = 1'b0;
      or_mask = 8'h00;
      tick(2);
      check({8'h00, acc0}, 16'h00B5);
      $display("alu table done");
      {ctrl_we, ctrl_wdata} = {1'b1, 8'hA5};
      tick(1);
      {ctrl_we, ctrl_wdata} = {1'b0, 8'h5A};
      tick(1);
      check({8'h00, ctrl_route}, 16'h00A5);
      {sc_en, ctrl_we} = 2'b01;
      tick(1);
      ctrl_we = 1'b0;
      tick(1);
      check({8'h00, ctrl_route}, 16'h00A5);
      sc_en = 1'b1;
      {stat_sticky_en, stat_route} = 16'h0103;
      tick(1);
      stat_route = 8'h00;
      tick(2);
      check({8'h00, stat_rdata}, 16'h0001);
      stat_rd = 1'b1;
      tick(1);
      stat_rd = 1'b0;
      tick(2);
      check({8'h00, stat_rdata}, 16'h0000);
      // event and read-clear in one cycle: the set must win
      {stat_route, stat_rd} = {8'h01, 1'b1};
      tick(1);
      {stat_route, stat_rd} = 9'h000;
      tick(1);
      check({8'h00, stat_rdata}, 16'h0001);
      $display("control and status done");
      dp_en = 1'b1;
      tick(2);
      check({14'h0000, route_out[1:0]}, 16'h0002);
      // fifth byte meets a full queue and is dropped
      for (int i = 0; i < 5; i++) i_bus.push(8'h11 * i[7:0]);
      tick(2);
      check({14'h0000, route_out[1:0]}, 16'h0001);
      {cfg_waddr, cfg_wdata, cfg_we} = {3'h1, 16'h3000, 1'b1};
      tick(1);
      cfg_we = 1'b0;
      // slot one loads acc0 from the queue head, so each read shows its byte
      for (int k = 0; k < 4; k++) begin
         route_in = 6'h11;
         tick(1);
         check({8'h00, acc0}, {8'h00, 8'h11 * k[7:0]});
      end
      route_in = 6'h00;
      tick(2);
      check({14'h0000, route_out[1:0]}, 16'h0002);
      // output buffer: internal write of acc0, bus side sees the head
      q0_is_out = 1'b1;
      route_in = 6'h08;
      tick(1);
      route_in = 6'h00;
      tick(2);
      check({q0_rdata, 6'h00, route_out[1:0]}, 16'h3500);
      $display("queue test done");
      cmp_mask0 = 8'hFF;
      tick(2);
      check({12'h000, chain_nx, route_out[2]}, 16'h0003);
      cmp_sel = 2'h3;
      tick(2);
      check({12'h000, chain_nx, route_out[2]}, 16'h0000);
      {cmp_sel, chain_mode} = 4'h1;
      tick(2);
      check({12'h000, chain_nx, route_out[2]}, 16'h0000);
      {chain_mode, cfg_waddr, cfg_wdata, cfg_we} = {2'h0, 3'h2, 16'h2180, 1'b1};
      tick(1);
      {cfg_we, route_in} = {1'b0, 6'h02};
      tick(1);
      check({acc0, acc1}, 16'h3553);
      {route_in, msb_pos} = {6'h00, 3'h3};
      tick(2);
      check({8'h00, acc0}, 16'h0005);
      $display("compare and width test done");
      close_out;
   end
endmodule

// *** clc_pkg.sv ***
// clc_pkg: shared types and constants for the configurable logic cell datapath
// assumes a single 10 MHz system clock and synchronous active-high reset
package clc_pkg;

   localparam int unsigned DW         = 8;
   localparam int unsigned CFG_WORDS  = 8;
   localparam int unsigned CFG_W      = 16;
   localparam int unsigned Q_DEPTH    = 4;
   localparam int unsigned Q_PTR_W    = 2;
   localparam int unsigned Q_CNT_W    = 3;
   localparam int unsigned ROUTE_IN_W = 6;
   localparam int unsigned ROUTE_OUT_W = 6;
   localparam int unsigned COND_W     = 16;
   localparam int unsigned CTRL_W     = 8;
   localparam int unsigned STAT_W     = 8;

   // configuration word field positions
   localparam int unsigned CF_FUNC_LSB  = 0;
   localparam int unsigned CF_SRCA_LSB  = 3;
   localparam int unsigned CF_SRCB_LSB  = 5;
   localparam int unsigned CF_SHIFT_LSB = 7;
   localparam int unsigned CF_CIN_LSB   = 9;
   localparam int unsigned CF_SIN_LSB   = 11;
   localparam int unsigned CF_DST_LSB   = 12;
   localparam int unsigned CF_CRC_BIT   = 14;
   localparam int unsigned CF_BANK_BIT  = 15;

   // condition vector bit positions
   localparam int unsigned C_CMP0   = 0;
   localparam int unsigned C_CMP1   = 1;
   localparam int unsigned C_ZERO0  = 2;
   localparam int unsigned C_ZERO1  = 3;
   localparam int unsigned C_ONES0  = 4;
   localparam int unsigned C_ONES1  = 5;
   localparam int unsigned C_OVF    = 6;
   localparam int unsigned C_COUT   = 7;
   localparam int unsigned C_SOUT   = 8;
   localparam int unsigned C_Q0_EMP = 9;
   localparam int unsigned C_Q0_FUL = 10;
   localparam int unsigned C_Q1_EMP = 11;
   localparam int unsigned C_Q1_FUL = 12;
   localparam int unsigned C_CMPLT0 = 13;
   localparam int unsigned C_CMPLT1 = 14;
   localparam int unsigned C_CHAIN  = 15;

   localparam logic [DW-1:0]     BYTE_ZERO  = 8'h00;
   localparam logic [DW-1:0]     BYTE_ONES  = 8'hFF;
   localparam logic [CTRL_W-1:0] CTRL_RST   = 8'h00;
   localparam logic [STAT_W-1:0] STAT_RST   = 8'h00;

   typedef enum logic [2:0] {
      FN_PASS = 3'h0, FN_INC = 3'h1, FN_DEC = 3'h2, FN_ADD = 3'h3,
      FN_SUB  = 3'h4, FN_AND = 3'h5, FN_OR  = 3'h6, FN_XOR = 3'h7
   } clc_func_t;

   typedef enum logic [1:0] {
      SH_NONE = 2'h0, SH_LEFT = 2'h1, SH_RIGHT = 2'h2, SH_SWAP = 2'h3
   } clc_shift_t;

   typedef enum logic [1:0] {
      CI_ZERO = 2'h0, CI_ONE = 2'h1, CI_CHAIN = 2'h2, CI_REG = 2'h3
   } clc_cin_t;

   // one-hot register bank select, loaded from the configuration bank bit
   typedef enum logic [1:0] {
      ST_BANK0 = 2'b01, ST_BANK1 = 2'b10
   } clc_state_t;

   typedef struct packed {
      logic [DW-1:0] wdata;
      logic          wr;
      logic          rd;
   } clc_qbus_t;

   typedef struct packed {
      logic          cy;
      logic          sh;
      logic          cond;
   } clc_chain_t;

endpackage
